// *** rtl/scb_pkg.sv ***
// Package: constants for the serial channel bridge with escape detection
// Assumes a 50 MHz ref_clk; byte streams arrive as valid/data strobes
package scb_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50000000;
    localparam int GUARD_MS        = 1000;
    localparam int SPREAD_MS       = 2000;
    localparam int GUARD_CYC       = CLK_HZ / 1000 * GUARD_MS;
    localparam int SPREAD_CYC      = CLK_HZ / 1000 * SPREAD_MS;
    localparam int BLINK_MS        = 50;
    localparam int BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
    localparam int ESC_COUNT       = 3;
    // ------------------------------------------------------------
    // Characters and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ESC_RS232_RST = 8'h2D;
    localparam logic [7:0] ESC_LOGIC_RST = 8'h26;
    localparam logic [7:0] CH_RESUME     = 8'h01;
    localparam logic [7:0] CH_LOGON      = 8'h05;
    localparam logic [1:0] PORT_RS232    = 2'h1;
    localparam logic [1:0] PORT_LOGIC    = 2'h2;
    // Notice selectors
    localparam logic [1:0] NOTE_NONE     = 2'h0;
    localparam logic [1:0] NOTE_ESCAPE   = 2'h1;
    localparam logic [1:0] NOTE_RESUME   = 2'h2;
    // Capture format codes
    localparam logic [1:0] CAP_OFF       = 2'h0;
    localparam logic [1:0] CAP_TEXT      = 2'h1;
    localparam logic [1:0] CAP_COLOUR    = 2'h2;
    localparam logic [1:0] CAP_RAW       = 2'h3;
    // Bridge mode
    typedef enum logic [1:0] {
        SCB_IDLE    = 2'b00,
        SCB_BRIDGE  = 2'b01,
        SCB_COMMAND = 2'b10
    } scb_mode_t;
endpackage

// *** rtl/scb_esc_det.sv ***
// Escape guard detector for one serial port
// Assumes one-cycle byte strobes on ref_clk; idle timing counted in cycles
`timescale 1ns/1ps
module scb_esc_det
    import scb_pkg::*;
#(
    parameter int GUARD = scb_pkg::GUARD_CYC,
    parameter int SPREAD = scb_pkg::SPREAD_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    input  wire logic       arm,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic [7:0] esc_char,
    output logic            escape
);
    typedef enum logic [2:0] {
        ED_WAIT  = 3'b000,
        ED_GOT1  = 3'b001,
        ED_GOT2  = 3'b010,
        ED_POST  = 3'b011
    } scb_ed_t;
    typedef struct packed {
        scb_ed_t     st;
        logic [31:0] idle;
        logic [31:0] span;
        logic        escape;
    } scb_ed_state_t;
    scb_ed_state_t s, next_s;
    logic hit;

    always_comb begin
        next_s = s;
        hit = rx_valid && (rx_data == esc_char);
        next_s.escape = 1'b0;
        if (!(&s.idle)) begin
            next_s.idle = s.idle + 32'h1;
        end
        if (!(&s.span)) begin
            next_s.span = s.span + 32'h1;
        end
        if (rx_valid) begin
            next_s.idle = 32'h0;
        end
        case (s.st)
            ED_WAIT: begin
                if (hit && s.idle >= 32'(GUARD)) begin
                    next_s.st = ED_GOT1;
                    next_s.span = 32'h0;
                end
            end
            ED_GOT1, ED_GOT2: begin
                if (s.span >= 32'(SPREAD)) begin
                    next_s.st = ED_WAIT;
                end else if (hit) begin
                    next_s.st = (s.st == ED_GOT1) ? ED_GOT2 : ED_POST;
                end else if (rx_valid) begin
                    next_s.st = ED_WAIT;
                end
            end
            ED_POST: begin
                if (rx_valid) begin
                    next_s.st = ED_WAIT;
                end else if (s.idle >= 32'(GUARD)) begin
                    next_s.st = ED_WAIT;
                    next_s.escape = 1'b1;
                end
            end
            default: next_s.st = ED_WAIT;
        endcase
        if (!arm) begin
            next_s.st = ED_WAIT;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s <= '{st: ED_WAIT, idle: 32'h0, span: 32'h0, escape: 1'b0};
        end else if (clk_en) begin
            s <= next_s;
        end
    end
    assign escape = s.escape;

    a_escape_after_third : assert property (@(posedge ref_clk) disable iff (!reset_n)
        s.escape && !$past(s.escape) |-> $past(s.st) == ED_POST)
        else $error("escape without three hits");
    a_escape_one_cycle : assert property (@(posedge ref_clk) disable iff (!reset_n)
        s.escape && clk_en |=> !s.escape)
        else $error("escape pulse longer than a cycle");
endmodule

// *** rtl/scb_bridge.sv ***
// Serial channel bridge with guarded escape to command mode
// Assumes UARTs outside supply rx strobes and accept tx strobes with ready;
// nonvolatile copies are held in an outside store loaded at power-up.
//
// Functional notes
// - While bridged, each byte received on one channel goes out the other.
// - Bridged state is kept across power loss and resumes on power return.
// - While bridged, received bytes are never taken as commands.
// - Escape needs three escape characters close together, one second idle around.
// - After escape, stay in command mode until connect, resume, or disable.
// - On escape, send the notice that the resume character restores bridging.
// - Ctrl+A resumes with a resumed notice; Ctrl+E logs on to command mode.
// - Default escape characters are minus on RS232 and ampersand on logic serial.
// - Each port's escape character is set separately by port index 1 or 2.
// - Escape detection per port matches only that port's own character.
// - With rate detect on, a rate change on one channel goes to the other.
// - Bridged: LED 7 and 10 off, LED 8 RS232 rx, LED 9 logic rx.
// - Settings select text, colour or raw capture, or disable capture.
// - A startup batch at power-up overrides the retained bridged state.
// - Operator waits one second, sends three within two, waits one, expects notice.
`timescale 1ns/1ps
module scb_bridge
    import scb_pkg::*;
#(
    parameter int GUARD = scb_pkg::GUARD_CYC,
    parameter int SPREAD = scb_pkg::SPREAD_CYC,
    parameter int BLINK = scb_pkg::BLINK_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // RS232 channel byte streams
    input  wire logic       rs232_rx_valid,
    input  wire logic [7:0] rs232_rx_data,
    output logic            rs232_tx_valid,
    output logic [7:0]      rs232_tx_data,
    input  wire logic       rs232_tx_ready,
    // Logic-level serial channel byte streams
    input  wire logic       logic_rx_valid,
    input  wire logic [7:0] logic_rx_data,
    output logic            logic_tx_valid,
    output logic [7:0]      logic_tx_data,
    input  wire logic       logic_tx_ready,
    // Command interpreter side
    input  wire logic       cmd_connect,
    input  wire logic       cmd_disconnect,
    input  wire logic       cmd_set_esc,
    input  wire logic [1:0] cmd_esc_port,
    input  wire logic [7:0] cmd_esc_char,
    input  wire logic [1:0] cmd_capture,
    output logic            cmd_rx_valid,
    output logic [7:0]      cmd_rx_data,
    output logic            logon,
    // Nonvolatile store
    input  wire logic       nv_load,
    input  wire logic       nv_bridge,
    input  wire logic [7:0] nv_esc_rs232,
    input  wire logic [7:0] nv_esc_logic,
    input  wire logic       startup_batch_valid,
    input  wire logic       startup_batch_bridge,
    output logic            nv_write,
    output logic            nv_bridge_out,
    output logic [7:0]      nv_esc_rs232_out,
    output logic [7:0]      nv_esc_logic_out,
    // Rate detection
    input  wire logic       rate_detect_enable,
    input  wire logic       rs232_rate_chg,
    input  wire logic       logic_rate_chg,
    input  wire logic [3:0] rs232_rate,
    input  wire logic [3:0] logic_rate,
    output logic            rs232_rate_set,
    output logic            logic_rate_set,
    output logic [3:0]      rate_out,
    // Status
    output logic [1:0]      mode,
    output logic            capture_colour_enable,
    output logic            raw_capture_enable,
    output logic            capture_disable,
    output logic [3:0]      led_bar,
    output logic [1:0]      notice_req
);
    typedef struct packed {
        scb_mode_t   mode;
        logic [7:0]  esc1;
        logic [7:0]  esc2;
        logic        tx1_v;
        logic [7:0]  tx1_d;
        logic        tx2_v;
        logic [7:0]  tx2_d;
        logic        crx_v;
        logic [7:0]  crx_d;
        logic        logon;
        logic        nv_wr;
        logic        cap_col;
        logic        cap_raw;
        logic        cap_off;
        logic        rset1;
        logic        rset2;
        logic [3:0]  rate;
        logic [31:0] blink1;
        logic [31:0] blink2;
        logic [3:0]  leds;
        logic [1:0]  note;
    } scb_state_t;
    scb_state_t s, next_s;
    logic esc1_hit, esc2_hit, bridged;

    assign bridged = (s.mode == SCB_BRIDGE);

    scb_esc_det #(.GUARD(GUARD), .SPREAD(SPREAD)) u_det1 (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .arm(bridged),
        .rx_valid(rs232_rx_valid), .rx_data(rs232_rx_data), .esc_char(s.esc1),
        .escape(esc1_hit));
    scb_esc_det #(.GUARD(GUARD), .SPREAD(SPREAD)) u_det2 (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .arm(bridged),
        .rx_valid(logic_rx_valid), .rx_data(logic_rx_data), .esc_char(s.esc2),
        .escape(esc2_hit));

    always_comb begin
        next_s = s;
        next_s.crx_v = 1'b0;
        next_s.logon = 1'b0;
        next_s.nv_wr = 1'b0;
        next_s.note  = NOTE_NONE;
        next_s.rset1 = 1'b0;
        next_s.rset2 = 1'b0;
        if (rs232_tx_ready) begin
            next_s.tx1_v = 1'b0;
        end
        if (logic_tx_ready) begin
            next_s.tx2_v = 1'b0;
        end
        // ------------------------------------------------------------
        // Forwarding and command routing
        // ------------------------------------------------------------
        if (bridged) begin
            if (rs232_rx_valid) begin
                next_s.tx2_v = 1'b1;
                next_s.tx2_d = rs232_rx_data;
            end
            if (logic_rx_valid) begin
                next_s.tx1_v = 1'b1;
                next_s.tx1_d = logic_rx_data;
            end
        end else if (rs232_rx_valid || logic_rx_valid) begin
            next_s.crx_d = rs232_rx_valid ? rs232_rx_data : logic_rx_data;
            if (s.mode == SCB_COMMAND && next_s.crx_d == CH_RESUME) begin
                next_s.mode = SCB_BRIDGE;
                next_s.note = NOTE_RESUME;
            end else if (next_s.crx_d == CH_LOGON) begin
                next_s.logon = 1'b1;
            end else begin
                next_s.crx_v = 1'b1;
            end
        end
        // ------------------------------------------------------------
        // Escape and mode commands
        // ------------------------------------------------------------
        if (bridged && (esc1_hit || esc2_hit)) begin
            next_s.mode = SCB_COMMAND;
            next_s.note = NOTE_ESCAPE;
        end
        if (!bridged && cmd_connect) begin
            next_s.mode = SCB_BRIDGE;
            next_s.nv_wr = 1'b1;
        end
        if (!bridged && cmd_disconnect) begin
            next_s.mode = SCB_IDLE;
            next_s.nv_wr = 1'b1;
        end
        if (!bridged && cmd_set_esc) begin
            if (cmd_esc_port == PORT_RS232) begin
                next_s.esc1 = cmd_esc_char;
                next_s.nv_wr = 1'b1;
            end else if (cmd_esc_port == PORT_LOGIC) begin
                next_s.esc2 = cmd_esc_char;
                next_s.nv_wr = 1'b1;
            end
        end
        if (!bridged) begin
            next_s.cap_col = (cmd_capture == CAP_COLOUR);
            next_s.cap_raw = (cmd_capture == CAP_RAW);
            next_s.cap_off = (cmd_capture == CAP_OFF);
        end
        if (nv_load) begin
            next_s.mode = nv_bridge ? SCB_BRIDGE : SCB_IDLE;
            next_s.esc1 = nv_esc_rs232;
            next_s.esc2 = nv_esc_logic;
            if (startup_batch_valid) begin
                next_s.mode = startup_batch_bridge ? SCB_BRIDGE : SCB_IDLE;
                next_s.nv_wr = 1'b1;
            end
        end
        // ------------------------------------------------------------
        // Rate propagation
        // ------------------------------------------------------------
        if (bridged && rate_detect_enable) begin
            if (rs232_rate_chg) begin
                next_s.rate = rs232_rate;
                next_s.rset2 = 1'b1;
            end else if (logic_rate_chg) begin
                next_s.rate = logic_rate;
                next_s.rset1 = 1'b1;
            end
        end
        // ------------------------------------------------------------
        // Activity LEDs
        // ------------------------------------------------------------
        if (s.blink1 != 32'h0) begin
            next_s.blink1 = s.blink1 - 32'h1;
        end
        if (s.blink2 != 32'h0) begin
            next_s.blink2 = s.blink2 - 32'h1;
        end
        if (rs232_rx_valid) begin
            next_s.blink1 = 32'(BLINK);
        end
        if (logic_rx_valid) begin
            next_s.blink2 = 32'(BLINK);
        end
        next_s.leds = bridged ? {1'b0, next_s.blink2 != 32'h0, next_s.blink1 != 32'h0, 1'b0}
                              : 4'h0;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s <= '0;
            s.mode <= SCB_IDLE;
            s.esc1 <= ESC_RS232_RST;
            s.esc2 <= ESC_LOGIC_RST;
            s.cap_off <= 1'b1;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign rs232_tx_valid        = s.tx1_v;
    assign rs232_tx_data         = s.tx1_d;
    assign logic_tx_valid        = s.tx2_v;
    assign logic_tx_data         = s.tx2_d;
    assign cmd_rx_valid          = s.crx_v;
    assign cmd_rx_data           = s.crx_d;
    assign logon                 = s.logon;
    assign nv_write              = s.nv_wr;
    // Bridge is the only mode code with bit 0 set
    assign nv_bridge_out         = s.mode[0];
    assign nv_esc_rs232_out      = s.esc1;
    assign nv_esc_logic_out      = s.esc2;
    assign rs232_rate_set        = s.rset1;
    assign logic_rate_set        = s.rset2;
    assign rate_out              = s.rate;
    assign mode                  = s.mode;
    assign capture_colour_enable = s.cap_col;
    assign raw_capture_enable    = s.cap_raw;
    assign capture_disable       = s.cap_off;
    assign led_bar               = s.leds;
    assign notice_req            = s.note;

    a_fwd_rs232_logic : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridged && rs232_rx_valid |=> logic_tx_valid && logic_tx_data == $past(rs232_rx_data))
        else $error("rs232 byte not forwarded");
    a_fwd_logic_rs232 : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridged && logic_rx_valid |=> rs232_tx_valid && rs232_tx_data == $past(logic_rx_data))
        else $error("logic byte not forwarded");
    a_no_cmd_bridged : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridged |=> !cmd_rx_valid)
        else $error("command byte while bridged");
    a_escape_notice : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridged && esc1_hit && !nv_load |=> notice_req == NOTE_ESCAPE && mode == SCB_COMMAND)
        else $error("escape notice missing");
    sequence resume_seq;
        clk_en && s.mode == SCB_COMMAND && rs232_rx_valid && rs232_rx_data == CH_RESUME && !nv_load
        && !cmd_disconnect;
    endsequence
    a_resume_notice : assert property (@(posedge ref_clk) disable iff (!reset_n)
        resume_seq |=> mode == SCB_BRIDGE && notice_req == NOTE_RESUME)
        else $error("resume failed");
    a_command_holds : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && s.mode == SCB_COMMAND && !rs232_rx_valid && !logic_rx_valid && !cmd_connect
        && !cmd_disconnect && !nv_load |=> mode == SCB_COMMAND)
        else $error("left command mode");
    a_leds_edges_off : assert property (@(posedge ref_clk) disable iff (!reset_n)
        led_bar[0] == 1'b0 && led_bar[3] == 1'b0)
        else $error("LED 7 or 10 lit");
    a_batch_override : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && nv_load && startup_batch_valid && !startup_batch_bridge |=> mode == SCB_IDLE)
        else $error("batch did not override");
    a_rate_follow : assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridged && rate_detect_enable && rs232_rate_chg |=> logic_rate_set && rate_out == $past(rs232_rate))
        else $error("rate not propagated");
endmodule

// *** test/scb_term.sv ***
// Terminal model for one serial port of the bridge
// Assumes byte strobes on ref_clk; sink may stall when slow is high
`timescale 1ns/1ps
module scb_term (
    input  wire logic       ref_clk,
    input  wire logic       slow,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] q[$];
    logic [1:0] ph;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b1;
        ph       = 2'h0;
    end
    // Stalling sink, ready one cycle in four while slow is high
    always @(posedge ref_clk) begin
        if (tx_valid && tx_ready) q.push_back(tx_data);
        ph       <= ph + 2'h1;
        tx_ready <= !slow || (ph == 2'h3);
    end
    // One byte strobe; released data shows its inverse
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask
endmodule

// *** test/serial_channel_bridge_escape_tb.sv ***
// Testbench for the serial channel bridge with escape detection
// Assumes short GUARD/SPREAD/BLINK counts and two terminal models
`timescale 1ns/1ps
module serial_channel_bridge_escape_tb;
    import scb_pkg::*;
    localparam int G = 20;
    logic ref_clk, reset_n, clk_en, rs232_rx_valid, rs232_tx_valid, rs232_tx_ready, logic_rx_valid;
    logic logic_tx_valid, logic_tx_ready, cmd_connect, cmd_disconnect, cmd_set_esc, cmd_rx_valid, logon;
    logic nv_load, nv_bridge, startup_batch_valid, startup_batch_bridge, nv_write, nv_bridge_out;
    logic rate_detect_enable, rs232_rate_chg, logic_rate_chg, rs232_rate_set, logic_rate_set;
    logic capture_colour_enable, raw_capture_enable, capture_disable, slow;
    logic [7:0] rs232_rx_data, rs232_tx_data, logic_rx_data, logic_tx_data, cmd_esc_char, cmd_rx_data;
    logic [7:0] nv_esc_rs232, nv_esc_logic, nv_esc_rs232_out, nv_esc_logic_out, rnd;
    logic [1:0] cmd_esc_port, cmd_capture, mode, notice_req;
    logic [3:0] rs232_rate, logic_rate, rate_out, led_bar;
    int         error_cnt, comparisons, cyc, bad3, bad12;

    always #10 ref_clk = ~ref_clk;
    scb_bridge #(.GUARD(G), .SPREAD(60), .BLINK(4)) DUT (
        .ref_clk, .reset_n, .clk_en, .rs232_rx_valid, .rs232_rx_data, .rs232_tx_valid, .rs232_tx_data,
        .rs232_tx_ready, .logic_rx_valid, .logic_rx_data, .logic_tx_valid, .logic_tx_data, .logic_tx_ready,
        .cmd_connect, .cmd_disconnect, .cmd_set_esc, .cmd_esc_port, .cmd_esc_char, .cmd_capture,
        .cmd_rx_valid, .cmd_rx_data, .logon, .nv_load, .nv_bridge, .nv_esc_rs232, .nv_esc_logic,
        .startup_batch_valid, .startup_batch_bridge, .nv_write, .nv_bridge_out, .nv_esc_rs232_out,
        .nv_esc_logic_out, .rate_detect_enable, .rs232_rate_chg, .logic_rate_chg, .rs232_rate, .logic_rate,
        .rs232_rate_set, .logic_rate_set, .rate_out, .mode, .capture_colour_enable, .raw_capture_enable,
        .capture_disable, .led_bar, .notice_req);
    scb_term u_rs (.ref_clk(ref_clk), .slow(slow), .rx_valid(rs232_rx_valid), .rx_data(rs232_rx_data),
                   .tx_valid(rs232_tx_valid), .tx_data(rs232_tx_data), .tx_ready(rs232_tx_ready));
    scb_term u_lg (.ref_clk(ref_clk), .slow(slow), .rx_valid(logic_rx_valid), .rx_data(logic_rx_data),
                   .tx_valid(logic_tx_valid), .tx_data(logic_tx_data), .tx_ready(logic_tx_ready));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_f(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s flag %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic close_out;
        $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmd(input int k);
        @(posedge ref_clk);
        case (k)
            0: cmd_connect <= 1'b1;
            1: cmd_disconnect <= 1'b1;
            2: cmd_set_esc <= 1'b1;
            default: nv_load <= 1'b1;
        endcase
        @(posedge ref_clk);
        {cmd_connect, cmd_disconnect, cmd_set_esc, nv_load} <= 4'h0;
        #1;
    endtask
    task automatic setesc(input logic [1:0] p, input logic [7:0] c);
        @(posedge ref_clk);
        cmd_esc_port <= p;
        cmd_esc_char <= c;
        cmd(2);
    endtask
    task automatic tx(input bit p, input logic [7:0] b);
        if (p) u_lg.send(b);
        else u_rs.send(b);
        #1;
    endtask
    task automatic fwd(input bit p, input logic [7:0] b);
        logic seen;
        u_rs.q.delete();
        u_lg.q.delete();
        tx(p, b);
        chk_f(p ? rs232_tx_valid : logic_tx_valid, 1'b1, "tx valid");
        chk(p ? rs232_tx_data : logic_tx_data, b, "tx data");
        seen = led_bar[p ? 2 : 1];
        tick(1);
        chk_f(seen | led_bar[p ? 2 : 1], 1'b1, "rx led");
        for (int i = 0; i < 10 && (p ? u_rs.q.size() : u_lg.q.size()) == 0; i++) tick(1);
        chk_f((p ? u_rs.q.size() : u_lg.q.size()) == 1, 1'b1, "sink count");
        if (p ? u_rs.q.size() : u_lg.q.size()) chk(p ? u_rs.q[0] : u_lg.q[0], b, "sink byte");
    endtask
    task automatic esc(input bit p, input logic [7:0] c, input int n, input logic [1:0] expn);
        logic [1:0] nt;
        nt = 2'h0;
        u_lg.q.delete();
        tick(G + 5);
        repeat (n) tx(p, c);
        for (int i = 0; i < G + 20 && nt == 2'h0; i++) begin
            tick(1);
            nt = notice_req;
        end
        chk(nt, expn, "notice");
        chk(mode, expn == NOTE_ESCAPE ? SCB_COMMAND : SCB_BRIDGE, "mode after guard");
    endtask
    task automatic rate(input bit p, input logic en, input logic [3:0] r);
        @(posedge ref_clk);
        rate_detect_enable <= en;
        if (p) {logic_rate_chg, logic_rate} <= {1'b1, r};
        else {rs232_rate_chg, rs232_rate} <= {1'b1, r};
        @(posedge ref_clk);
        {rs232_rate_chg, logic_rate_chg} <= 2'h0;
        #1;
        chk_f(p ? rs232_rate_set : logic_rate_set, en, "rate set");
        if (en) chk(rate_out, r, "rate");
    endtask
    // ----------------------------------------
    // Monitors and timeout
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (reset_n && mode == SCB_BRIDGE && (cmd_rx_valid || logon)) bad3++;
        if (reset_n && mode == SCB_BRIDGE && (led_bar[0] || led_bar[3])) bad12++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        clk_en  = 1'b1;
        {cmd_connect, cmd_disconnect, cmd_set_esc, cmd_esc_port, cmd_esc_char, cmd_capture, nv_load, nv_bridge,
         nv_esc_rs232, nv_esc_logic, startup_batch_valid, startup_batch_bridge, rate_detect_enable,
         rs232_rate_chg, logic_rate_chg, rs232_rate, logic_rate, slow} = '0;
        tick(5);
        reset_n <= 1'b1;
        chk(mode, SCB_IDLE, "reset mode");
        chk(led_bar, 4'h0, "reset leds");
        for (int c = 0; c < 4; c++) begin
            @(posedge ref_clk);
            cmd_capture <= c[1:0];
            tick(2);
            chk_f(capture_colour_enable, c == 2, "colour");
            chk_f(raw_capture_enable, c == 3, "raw");
            chk_f(capture_disable, c == 0, "capture off");
        end
        tx(1, 8'h05);
        chk_f(logon, 1'b1, "logon");
        tx(1, 8'h41);
        chk_f(cmd_rx_valid, 1'b1, "idle cmd valid");
        chk(cmd_rx_data, 8'h41, "idle cmd byte");
        $display("test idle done");
        cmd(0);
        chk(mode, SCB_BRIDGE, "connect");
        chk_f(nv_write & nv_bridge_out, 1'b1, "nv store");
        rnd = 8'h58;
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            slow <= rnd[0];
            fwd(rnd[1], lfsr(rnd));
        end
        // Full-rate sinks: escape bytes come every other cycle
        slow <= 1'b0;
        setesc(2'h1, 8'h5A);
        chk_f(nv_write, 1'b0, "set while bridged");
        rate(0, 1'b1, 4'h5);
        rate(1, 1'b1, 4'hA);
        rate(0, 1'b0, 4'h3);
        $display("test forward done");
        esc(0, 8'h26, 3, NOTE_NONE);
        esc(1, 8'h2D, 3, NOTE_NONE);
        esc(0, 8'h2D, 1, NOTE_NONE);
        esc(0, 8'h2D, 2, NOTE_NONE);
        esc(0, 8'h2D, 3, NOTE_ESCAPE);
        chk(u_lg.q.size(), 8'h03, "escape bytes forwarded");
        tx(0, 8'h78);
        chk(cmd_rx_data, 8'h78, "command byte");
        chk(mode, SCB_COMMAND, "command mode");
        tx(1, 8'h05);
        chk_f(logon, 1'b1, "logon");
        tx(0, 8'h01);
        chk(notice_req, NOTE_RESUME, "resume notice");
        chk(mode, SCB_BRIDGE, "resumed");
        esc(1, 8'h26, 3, NOTE_ESCAPE);
        $display("test escape done");
        setesc(2'h1, 8'h42);
        chk(nv_esc_rs232_out, 8'h42, "esc rs232");
        setesc(2'h2, 8'h7E);
        chk(nv_esc_logic_out, 8'h7E, "esc logic");
        cmd(0);
        chk(mode, SCB_BRIDGE, "reconnect");
        esc(0, 8'h2D, 3, NOTE_NONE);
        esc(0, 8'h42, 3, NOTE_ESCAPE);
        cmd(1);
        chk(mode, SCB_IDLE, "disconnect");
        {nv_bridge, nv_esc_rs232, nv_esc_logic} <= {1'b1, 8'h2D, 8'h26};
        cmd(3);
        chk(mode, SCB_BRIDGE, "nv resume");
        chk(nv_esc_rs232_out, 8'h2D, "nv esc rs232");
        chk(nv_esc_logic_out, 8'h26, "nv esc logic");
        {startup_batch_valid, startup_batch_bridge} <= 2'b10;
        cmd(3);
        chk(mode, SCB_IDLE, "batch override");
        clk_en <= 1'b0;
        cmd(0);
        chk(mode, SCB_IDLE, "frozen connect");
        clk_en <= 1'b1;
        $display("test store done");
        chk(bad3, 8'h00, "bridged commands");
        chk(bad12, 8'h00, "bridged leds");
        close_out();
    end
endmodule
